//--- hdl/timer16_regs.svh
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// Byte offsets on the register port
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_CONTROL_THIRD 4'h2
`define OFS_COUNT_LOW 4'h3
`define OFS_COUNT_HIGH_LOCATION 4'h4
`define OFS_COMPARE_A_LOW 4'h5
`define OFS_COMPARE_A_HIGH 4'h6
`define OFS_COMPARE_B_LOW 4'h7
`define OFS_COMPARE_B_HIGH 4'h8
`define OFS_COMPARE_C_LOW 4'h9
`define OFS_COMPARE_C_HIGH 4'hA
`define OFS_CAPTURE_LOW 4'hB
`define OFS_CAPTURE_HIGH 4'hC
`define OFS_SHARED_FLAG 4'hD
`define OFS_SHARED_MASK 4'hE

// Field positions
`define BIT_WAVEFORM_MODE_BIT3 4
`define BIT_WAVEFORM_MODE_BIT2 3
`define BIT_NOISE_FILTER 7
`define BIT_CAPTURE_RISING 6
`define BIT_CAPTURE_FROM_COMPARATOR 5
`define BIT_FORCE_COMPARE_A 7
`define FLAG_WRAP 0
`define FLAG_COMPARE_A 1
`define FLAG_COMPARE_C 3
`define FLAG_CAPTURE 4

// Reset values and fixed limits
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define LIMIT_BOTTOM 16'h0000
`define LIMIT_MAX 16'hFFFF
`define LIMIT_8BIT 16'h00FF
`define LIMIT_9BIT 16'h01FF
`define LIMIT_10BIT 16'h03FF
`define FILTER_SAMPLES 4

`endif

//--- hdl/timer16_pkg.sv
package timer16_pkg;
   `include "timer16_regs.svh"

   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } clock_select_type;

   typedef struct packed {
      logic [7:0] controlA;
      logic [7:0] controlB;
      logic [15:0] countValue;
      logic [2:0][15:0] compareBuffer;
      logic [2:0][15:0] compareActive;
      logic [15:0] captureValue;
      logic [7:0] highLatch;
      logic [4:0] sharedFlag;
      logic [4:0] sharedMask;
      logic [9:0] prescale;
      logic [2:0] extSync;
      logic [1:0] pinSync;
      logic [1:0] cmpSync;
      logic [1:0] legacySync;
      logic [`FILTER_SAMPLES-1:0] captureHistory;
      logic captureLevel;
      logic ack;
      logic [7:0] readData;
      logic [2:0] outPins;
      logic atBottom;
      logic atMax;
   } timer_state_type;
endpackage

//--- hdl/timer16_register_access.sv
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "timer16_regs.svh"
// Behaviour
// - Legacy fuse removes compare channel C.
// - Counter, compares, capture 16 bits; controls 8.
// - Count only on selected tick; stop otherwise.
// - Buffered compares continuously matched, drive pins.
// - Compare match sets channel match flag.
// - Filtered capture edge copies counter value.
// - Top from compare A, capture, or limits.
// - Compare A as PWM top: buffered, no output.
// - Bottom indicated when counter is zero.
// - Max indicated at 0xFFFF regardless of top.
// - One shared high-byte latch per timer.
// - Low write loads latch plus low byte.
// - Low read copies high byte into latch.
// - Compare reads direct, latch untouched.
// - Third control holds force bits; mode bit3 moved.
// - Requests shown as flags, gated by mask.
// - Counter high location reaches the latch.
// - Counter write beats clear or count.
module timer16_register_access (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   output logic [7:0] readdata,
   output logic waitrequest,
   // Pins and events
   input wire logic legacyFuse,
   input wire logic externalCountPin,
   input wire logic captureInputPin,
   input wire logic comparatorOutput,
   output logic [2:0] compareOutputPins,
   output logic [4:0] interruptRequest,
   output logic atBottom,
   output logic atMax
);
   import timer16_pkg::*;

   timer_state_type state;
   timer_state_type next_state;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] top_value(input logic [3:0] mode, input logic [15:0] cmpA,
                                             input logic [15:0] cap);
      case (mode)
         4'h1, 4'h5: top_value = `LIMIT_8BIT;
         4'h2, 4'h6: top_value = `LIMIT_9BIT;
         4'h3, 4'h7: top_value = `LIMIT_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: top_value = cmpA;
         4'h8, 4'hA, 4'hC, 4'hE: top_value = cap;
         default: top_value = `LIMIT_MAX;
      endcase
   endfunction

   function automatic logic is_pwm(input logic [3:0] mode);
      is_pwm = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hC || mode == 4'hD);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] mode;
   logic legacy;
   logic timerTick;
   logic [15:0] topValue;
   logic pwm;
   logic topFromA;
   logic topFromCapture;
   logic request;
   logic firstEdge;
   logic commitWrite;
   logic countWrite;
   logic [2:0] match;
   logic [2:0] chanOn;
   logic captureRaw;
   logic filtered;
   logic captureEvent;
   logic [4:0] flagSet;
   logic [4:0] flagClear;

   assign mode = {state.controlB[`BIT_WAVEFORM_MODE_BIT3],
                  state.controlB[`BIT_WAVEFORM_MODE_BIT2], state.controlA[1:0]};
   assign legacy = state.legacySync[1];
   assign chanOn = {!legacy, 2'b11};
   assign topValue = top_value(mode, state.compareActive[0], state.captureValue);
   assign pwm = is_pwm(mode);
   assign topFromA = (mode == 4'h4 || mode == 4'h9 || mode == 4'hB || mode == 4'hF);
   assign topFromCapture = (mode == 4'h8 || mode == 4'hA || mode == 4'hC || mode == 4'hE);
   assign request = read || write;
   assign firstEdge = request && !state.ack;
   // Writes land on the edge where waitrequest is low, as the master sees it
   assign commitWrite = write && state.ack;
   assign countWrite = commitWrite && address == `OFS_COUNT_LOW;
   assign waitrequest = request && !state.ack;
   assign readdata = state.readData;
   assign compareOutputPins = state.outPins;
   assign interruptRequest = state.sharedFlag & state.sharedMask;
   assign atBottom = state.atBottom;
   assign atMax = state.atMax;

   // Timer tick from prescaler or synchronised external pin
   always_comb begin
      case (clock_select_type'(state.controlB[2:0]))
         CS_STOP: timerTick = 1'b0;
         CS_DIV1: timerTick = 1'b1;
         CS_DIV8: timerTick = &state.prescale[2:0];
         CS_DIV64: timerTick = &state.prescale[5:0];
         CS_DIV256: timerTick = &state.prescale[7:0];
         CS_DIV1024: timerTick = &state.prescale;
         CS_EXT_FALL: timerTick = state.extSync[2] && !state.extSync[1];
         default: timerTick = !state.extSync[2] && state.extSync[1];
      endcase
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         match[i] = timerTick && chanOn[i] && state.countValue == state.compareActive[i];
      end
   end

   // Capture source, then optional filter that needs a full run of equal samples
   assign captureRaw = state.controlB[`BIT_CAPTURE_FROM_COMPARATOR] ? state.cmpSync[1]
                                                                   : state.pinSync[1];
   always_comb begin
      filtered = state.captureLevel;
      if (!state.controlB[`BIT_NOISE_FILTER]) begin
         filtered = captureRaw;
      end else if (&state.captureHistory) begin
         filtered = 1'b1;
      end else if (~|state.captureHistory) begin
         filtered = 1'b0;
      end
   end
   assign captureEvent = filtered != state.captureLevel &&
                         filtered == state.controlB[`BIT_CAPTURE_RISING];

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      flagSet = 5'h00;
      flagClear = 5'h00;
      next_state.extSync = {state.extSync[1:0], externalCountPin};
      next_state.pinSync = {state.pinSync[0], captureInputPin};
      next_state.cmpSync = {state.cmpSync[0], comparatorOutput};
      next_state.legacySync = {state.legacySync[0], legacyFuse};
      next_state.captureHistory = {state.captureHistory[`FILTER_SAMPLES-2:0], captureRaw};
      next_state.captureLevel = filtered;
      next_state.prescale = (state.controlB[2:0] == CS_STOP) ? 10'h000
                                                             : state.prescale + 10'h001;
      next_state.ack = firstEdge;

      // Counter
      if (timerTick) begin
         if (state.countValue == topValue) begin
            next_state.countValue = `RESET_WORD;
            flagSet[`FLAG_WRAP] = 1'b1;
            if (pwm) begin
               next_state.compareActive = state.compareBuffer;
            end
         end else begin
            next_state.countValue = state.countValue + 16'h0001;
         end
      end
      flagSet[`FLAG_COMPARE_C:`FLAG_COMPARE_A] = match;

      // Waveform: toggle on match in non-PWM modes, level compare in PWM modes
      for (int i = 0; i < 3; i++) begin
         if (!chanOn[i]) begin
            next_state.outPins[i] = 1'b0;
         end else if (pwm) begin
            next_state.outPins[i] = (i == 0 && topFromA) ? 1'b0
                                    : state.countValue < state.compareActive[i];
         end else if (match[i]) begin
            next_state.outPins[i] = !state.outPins[i];
         end
      end

      if (captureEvent) begin
         next_state.captureValue = state.countValue;
         flagSet[`FLAG_CAPTURE] = 1'b1;
      end

      // Reads: data and latch side effect on the first edge of the request
      if (firstEdge && read) begin
         next_state.readData = `RESET_BYTE;
         if (address == `OFS_CONTROL_A) begin
            next_state.readData = state.controlA;
         end else if (address == `OFS_CONTROL_B) begin
            next_state.readData = state.controlB;
         end else if (address == `OFS_COUNT_LOW) begin
            next_state.readData = state.countValue[7:0];
            next_state.highLatch = state.countValue[15:8];
         end else if (address == `OFS_COUNT_HIGH_LOCATION ||
                      address == `OFS_CAPTURE_HIGH) begin
            next_state.readData = state.highLatch;
         end else if (address == `OFS_COMPARE_A_LOW) begin
            next_state.readData = state.compareBuffer[0][7:0];
         end else if (address == `OFS_COMPARE_A_HIGH) begin
            next_state.readData = state.compareBuffer[0][15:8];
         end else if (address == `OFS_COMPARE_B_LOW) begin
            next_state.readData = state.compareBuffer[1][7:0];
         end else if (address == `OFS_COMPARE_B_HIGH) begin
            next_state.readData = state.compareBuffer[1][15:8];
         end else if (address == `OFS_COMPARE_C_LOW && !legacy) begin
            next_state.readData = state.compareBuffer[2][7:0];
         end else if (address == `OFS_COMPARE_C_HIGH && !legacy) begin
            next_state.readData = state.compareBuffer[2][15:8];
         end else if (address == `OFS_CAPTURE_LOW) begin
            next_state.readData = state.captureValue[7:0];
            next_state.highLatch = state.captureValue[15:8];
         end else if (address == `OFS_SHARED_FLAG) begin
            next_state.readData = {3'h0, state.sharedFlag};
         end else if (address == `OFS_SHARED_MASK) begin
            next_state.readData = {3'h0, state.sharedMask};
         end
      end

      // Writes: 16-bit registers load only on the low byte
      if (commitWrite) begin
         if (address == `OFS_CONTROL_A) begin
            next_state.controlA = writedata;
         end else if (address == `OFS_CONTROL_B) begin
            next_state.controlB = writedata;
         end else if (address == `OFS_CONTROL_THIRD) begin
            // Force bits are strobes: they toggle like a match but never set a flag
            for (int i = 0; i < 3; i++) begin
               if (writedata[`BIT_FORCE_COMPARE_A - i] && chanOn[i] && !pwm) begin
                  next_state.outPins[i] = !state.outPins[i];
               end
            end
         end else if (address == `OFS_COUNT_LOW) begin
            next_state.countValue = {state.highLatch, writedata};
         end else if (address == `OFS_COUNT_HIGH_LOCATION || address == `OFS_COMPARE_A_HIGH ||
                      address == `OFS_COMPARE_B_HIGH || address == `OFS_COMPARE_C_HIGH ||
                      address == `OFS_CAPTURE_HIGH) begin
            next_state.highLatch = writedata;
         end else if (address == `OFS_COMPARE_A_LOW || address == `OFS_COMPARE_B_LOW ||
                      (address == `OFS_COMPARE_C_LOW && !legacy)) begin
            for (int i = 0; i < 3; i++) begin
               if (address == `OFS_COMPARE_A_LOW + 4'(2 * i)) begin
                  next_state.compareBuffer[i] = {state.highLatch, writedata};
                  if (!pwm) begin
                     next_state.compareActive[i] = {state.highLatch, writedata};
                  end
               end
            end
         end else if (address == `OFS_CAPTURE_LOW && topFromCapture) begin
            // Capture is only writable while it defines the top
            next_state.captureValue = {state.highLatch, writedata};
         end else if (address == `OFS_SHARED_FLAG) begin
            flagClear = writedata[4:0];
         end else if (address == `OFS_SHARED_MASK) begin
            next_state.sharedMask = writedata[4:0];
         end
      end

      // Hardware set wins over a software clear in the same cycle
      next_state.sharedFlag = (state.sharedFlag & ~flagClear) | flagSet;
      if (legacy) begin
         next_state.sharedFlag[`FLAG_COMPARE_C] = 1'b0;
      end
      next_state.atBottom = next_state.countValue == `LIMIT_BOTTOM;
      next_state.atMax = next_state.countValue == `LIMIT_MAX;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
         state.atBottom <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_stopped_holds;
      @(posedge mclk) disable iff (!resetn)
      (state.controlB[2:0] == 3'h0 && !countWrite) |=> $stable(state.countValue);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while stopped");

   property p_low_write_loads;
      @(posedge mclk) disable iff (!resetn)
      countWrite |=> state.countValue == {$past(state.highLatch), $past(writedata)};
   endproperty
   a_low_write_loads: assert property (p_low_write_loads) else $error("counter write lost");

   property p_high_write_latch_only;
      @(posedge mclk) disable iff (!resetn)
      (commitWrite && address == `OFS_COMPARE_B_HIGH)
         |=> state.highLatch == $past(writedata) && $stable(state.compareBuffer);
   endproperty
   a_high_write_latch_only: assert property (p_high_write_latch_only) else $error("high write leaked");

   property p_low_read_latches;
      @(posedge mclk) disable iff (!resetn)
      (firstEdge && read && address == `OFS_COUNT_LOW)
         |=> state.highLatch == $past(state.countValue[15:8]) && !waitrequest;
   endproperty
   a_low_read_latches: assert property (p_low_read_latches) else $error("latch not loaded on read");

   property p_compare_read_direct;
      @(posedge mclk) disable iff (!resetn)
      (firstEdge && read && address == `OFS_COMPARE_A_LOW && !write)
         |=> $stable(state.highLatch) && readdata == $past(state.compareBuffer[0][7:0]);
   endproperty
   a_compare_read_direct: assert property (p_compare_read_direct) else $error("compare read wrong");

   property p_bottom_max;
      @(posedge mclk) disable iff (!resetn)
      atBottom == (state.countValue == 16'h0000) && atMax == (state.countValue == 16'hFFFF);
   endproperty
   a_bottom_max: assert property (p_bottom_max) else $error("bottom or max wrong");

   property p_match_flag;
      @(posedge mclk) disable iff (!resetn)
      (match[1]) |=> state.sharedFlag[2] ##1 (state.sharedFlag[2] || $past(flagClear[2]));
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match flag missing");

   property p_legacy_no_c;
      @(posedge mclk) disable iff (!resetn)
      legacy |=> !state.sharedFlag[3] && !compareOutputPins[2];
   endproperty
   a_legacy_no_c: assert property (p_legacy_no_c) else $error("channel C active in legacy");

   property p_request_gate;
      @(posedge mclk) disable iff (!resetn)
      interruptRequest == (state.sharedFlag & state.sharedMask);
   endproperty
   a_request_gate: assert property (p_request_gate) else $error("request not gated");

   property p_top_wrap;
      @(posedge mclk) disable iff (!resetn)
      (timerTick && state.countValue == topValue && !countWrite)
         |=> state.countValue == `LIMIT_BOTTOM && state.sharedFlag[`FLAG_WRAP];
   endproperty
   a_top_wrap: assert property (p_top_wrap) else $error("no wrap at top");
endmodule

//--- sim/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
   // Clock
   input wire logic mclk,
   // Avalon-MM master side
   output logic [3:0] address,
   output logic read,
   output logic write,
   output logic [7:0] writedata,
   input wire logic [7:0] readdata,
   input wire logic waitrequest
);
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request held until waitrequest is seen low at a rising edge
   task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge mclk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Released data must not look like the last byte
      writedata <= ~d;
   endtask

   // Both bytes back to back, nothing else may touch the latch between them
   task automatic write16(input logic [3:0] lo, input logic [15:0] v);
      logic [7:0] q;
      access(1'b1, lo + 4'h1, v[15:8], q);
      access(1'b1, lo, v[7:0], q);
   endtask

   task automatic read16(input logic [3:0] lo, output logic [15:0] v);
      access(1'b0, lo, 8'h00, v[7:0]);
      access(1'b0, lo + 4'h1, 8'h00, v[15:8]);
   endtask
endmodule

//--- sim/timer16_register_access_tb_top.sv
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_register_access_tb_top;
   import timer16_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic legacyFuse = 1'b0;
   logic externalCountPin = 1'b0;
   logic captureInputPin = 1'b0;
   logic comparatorOutput = 1'b0;
   logic [3:0] address;
   logic read;
   logic write;
   logic [7:0] writedata;
   logic [7:0] readdata;
   logic waitrequest;
   logic [2:0] compareOutputPins;
   logic [4:0] interruptRequest;
   logic atBottom;
   logic atMax;
   int n_fail = 0;
   int samples_checked = 0;
   integer seed = 32'h4935;

   always #50 mclk = ~mclk;

   timer16_register_access timer16_register_access_i (.mclk(mclk), .resetn(resetn),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .legacyFuse(legacyFuse),
      .externalCountPin(externalCountPin), .captureInputPin(captureInputPin),
      .comparatorOutput(comparatorOutput), .compareOutputPins(compareOutputPins),
      .interruptRequest(interruptRequest), .atBottom(atBottom), .atMax(atMax));

   cpu_bus_model cpu_bus_model_i (.mclk(mclk), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      cpu_bus_model_i.access(1'b1, a, d, q);
   endtask

   task automatic rd8(input logic [3:0] a, output logic [7:0] q);
      cpu_bus_model_i.access(1'b0, a, 8'h00, q);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Pass 4 runs mode 12, where the top is whatever capture holds
   function automatic logic [15:0] topOf(input int m);
      return m == 4 ? 16'h0040 : m == 1 ? `LIMIT_8BIT : m == 2 ? `LIMIT_9BIT :
             m == 3 ? `LIMIT_10BIT : `LIMIT_MAX;
   endfunction

   // Channel C vanishes while the compatibility fuse is set
   function automatic logic [15:0] compareCOf(input logic fuse, input logic [15:0] v);
      return fuse ? 16'h0000 : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      logic [15:0] w;
      logic [15:0] got;
      logic [7:0] b;
      logic [7:0] x;
      logic [2:0] pins;
      idle(3);
      check("bottom in reset", atBottom, 16'h0001);
      check("irq in reset", interruptRequest, 16'h0000);
      idle(2);
      resetn <= 1'b1;
      idle(3);
      b = 8'($random(seed));
      b[2:0] = 3'h0;
      wr8(`OFS_CONTROL_B, b);
      rd8(`OFS_CONTROL_B, x);
      check("controlB", x, b);
      wr8(`OFS_CONTROL_B, 8'h00);
      rd8(`OFS_CONTROL_THIRD, x);
      check("control third", x, 8'h00);
      wr8(4'hF, 8'hA5);
      rd8(4'hF, x);
      check("unmapped", x, 8'h00);
      v = 16'($random(seed));
      cpu_bus_model_i.write16(`OFS_COUNT_LOW, v);
      idle(3);
      cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
      check("count stopped", got, v);
      wr8(`OFS_COUNT_HIGH_LOCATION, ~v[15:8]);
      cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
      check("count after high write", got, v);
      w = 16'($random(seed));
      cpu_bus_model_i.write16(`OFS_COMPARE_A_LOW, w);
      rd8(`OFS_COUNT_LOW, x);
      cpu_bus_model_i.read16(`OFS_COMPARE_A_LOW, got);
      check("compare A", got, w);
      rd8(`OFS_COUNT_HIGH_LOCATION, x);
      check("latch kept", x, v[15:8]);
      b = 8'($random(seed));
      x = 8'($random(seed));
      wr8(`OFS_COUNT_HIGH_LOCATION, b);
      wr8(`OFS_COMPARE_B_LOW, x);
      wr8(`OFS_COUNT_LOW, ~x);
      cpu_bus_model_i.read16(`OFS_COMPARE_B_LOW, got);
      check("compare B shared", got, {b, x});
      cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
      check("count shared", got, {b, ~x});
      for (int f = 1; f >= 0; f--) begin
         legacyFuse <= f[0];
         idle(4);
         cpu_bus_model_i.write16(`OFS_COMPARE_C_LOW, w);
         cpu_bus_model_i.read16(`OFS_COMPARE_C_LOW, got);
         check("compare C", got, compareCOf(f[0], w));
      end
      cpu_bus_model_i.write16(`OFS_COUNT_LOW, `LIMIT_MAX);
      idle(2);
      check("max", {atMax, atBottom}, 16'h0002);
      cpu_bus_model_i.write16(`OFS_COUNT_LOW, `LIMIT_BOTTOM);
      idle(2);
      check("bottom", {atMax, atBottom}, 16'h0001);
      for (int m = 0; m < 5; m++) begin
         // Capture only takes a write while it defines the top, so set the mode first
         wr8(`OFS_CONTROL_B, m == 4 ? 8'h18 : 8'h00);
         wr8(`OFS_CONTROL_A, m == 4 ? 8'h00 : m[7:0]);
         if (m == 4) begin
            cpu_bus_model_i.write16(`OFS_CAPTURE_LOW, topOf(m));
         end
         cpu_bus_model_i.write16(`OFS_COUNT_LOW, topOf(m) - 16'h0003);
         wr8(`OFS_SHARED_FLAG, 8'h1F);
         wr8(`OFS_SHARED_MASK, 8'h01);
         wr8(`OFS_CONTROL_B, {m == 4 ? 5'h03 : 5'h00, CS_DIV1});
         for (int i = 0; i < 30 && interruptRequest[0] !== 1'b1; i++) @(posedge mclk);
         wr8(`OFS_CONTROL_B, 8'h00);
         check("wrap flag", interruptRequest[0], 16'h0001);
         cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
         check("wrapped count", got < 16'h0010, 16'h0001);
      end
      wr8(`OFS_SHARED_MASK, 8'h00);
      rd8(`OFS_SHARED_FLAG, x);
      check("masked irq", {interruptRequest, x[0]}, 16'h0001);
      wr8(`OFS_CONTROL_A, 8'h00);
      for (int ch = 0; ch < 3; ch++) begin
         cpu_bus_model_i.write16(`OFS_COUNT_LOW, 16'h0100);
         cpu_bus_model_i.write16(`OFS_COMPARE_A_LOW + 4'(2 * ch), 16'h0110);
         wr8(`OFS_SHARED_FLAG, 8'h1F);
         wr8(`OFS_SHARED_MASK, 8'h02 << ch);
         pins = compareOutputPins;
         wr8(`OFS_CONTROL_B, {5'h00, CS_DIV1});
         for (int i = 0; i < 40 && interruptRequest[ch + 1] !== 1'b1; i++) @(posedge mclk);
         wr8(`OFS_CONTROL_B, 8'h00);
         check("match irq", interruptRequest, 16'h0002 << ch);
         check("match pin", compareOutputPins[ch] ^ pins[ch], 16'h0001);
         wr8(`OFS_SHARED_FLAG, 8'h1F);
         rd8(`OFS_SHARED_FLAG, x);
         check("flag cleared", x[ch + 1], 16'h0000);
         pins = compareOutputPins;
         wr8(`OFS_CONTROL_THIRD, 8'h80 >> ch);
         idle(2);
         check("force pin", compareOutputPins[ch] ^ pins[ch], 16'h0001);
      end
      for (int s = 6; s < 8; s++) begin
         cpu_bus_model_i.write16(`OFS_COUNT_LOW, 16'h0000);
         wr8(`OFS_CONTROL_B, s[7:0]);
         repeat (5) begin
            externalCountPin <= 1'b1;
            idle(4);
            externalCountPin <= 1'b0;
            idle(4);
         end
         wr8(`OFS_CONTROL_B, 8'h00);
         cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
         check("external ticks", got, 16'h0005);
      end
      wr8(`OFS_CONTROL_B, {5'h00, CS_DIV1});
      cpu_bus_model_i.write16(`OFS_COUNT_LOW, 16'h1234);
      wr8(`OFS_CONTROL_B, 8'h00);
      cpu_bus_model_i.read16(`OFS_COUNT_LOW, got);
      check("write while counting", got - 16'h1234 < 16'h0010, 16'h0001);
      for (int src = 0; src < 3; src++) begin
         wr8(`OFS_CONTROL_B, src == 0 ? 8'h40 : src == 1 ? 8'h60 : 8'hC0);
         idle(4);
         v = 16'($random(seed));
         cpu_bus_model_i.write16(`OFS_COUNT_LOW, v);
         wr8(`OFS_SHARED_FLAG, 8'h1F);
         // A two-cycle spike must be swallowed by the filter
         if (src == 2) begin
            captureInputPin <= 1'b1;
            idle(2);
            captureInputPin <= 1'b0;
            idle(8);
            rd8(`OFS_SHARED_FLAG, x);
            check("filtered spike", x[4], 16'h0000);
         end
         captureInputPin <= src != 1;
         comparatorOutput <= src == 1;
         idle(10);
         rd8(`OFS_SHARED_FLAG, x);
         check("capture flag", x[4], 16'h0001);
         cpu_bus_model_i.read16(`OFS_CAPTURE_LOW, got);
         check("capture value", got, v);
         captureInputPin <= 1'b0;
         comparatorOutput <= 1'b0;
         idle(4);
      end
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      finish_test();
   end
endmodule
